// File: design/loopback_word_engine.sv
// loopback_word_engine: sends one manchester test word and checks the echo
// assumes rx_line is already synchronised to clk and start is a one-cycle pulse
`timescale 1ns/1ps

module loopback_word_engine #(
    parameter int HALF_CYC = selftest_pkg::HALF_BIT_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request
    input  wire logic        start,
    input  wire logic        sync_cmd,
    input  wire logic [15:0] word,
    // line
    input  wire logic        rx_line,
    output logic             tx_line,
    output logic             tx_on,
    // result
    output logic             done,
    output logic             fail,
    output logic [15:0]      rx_word
);
    localparam int             CW     = $clog2(HALF_CYC);
    localparam logic [CW-1:0]  SAMPLE = CW'(HALF_CYC / 2);
    localparam logic [CW-1:0]  ENDCYC = CW'(HALF_CYC - 1);

    generate
        // echo returns three cycles late (bus flop plus two sync flops), so mid-half must be later
        if (HALF_CYC < 6) begin : bad_half
            $error("loopback_word_engine: HALF_CYC must be at least 6");
        end
    endgenerate

    typedef enum logic {LB_IDLE, LB_SEND} lb_state_type;

    lb_state_type                                   state_r, state_nxt;
    logic [CW-1:0]                                  cyc_r, cyc_nxt;
    logic [5:0]                                     idx_r, idx_nxt;
    logic [selftest_pkg::FRAME_HALVES-1:0]          tx_sh_r, tx_sh_nxt;
    logic [selftest_pkg::FRAME_HALVES-1:0]          rx_sh_r, rx_sh_nxt;
    logic [15:0]                                    word_r, word_nxt;
    logic                                           sync_r, sync_nxt;
    logic                                           done_r, done_nxt;
    logic                                           fail_r, fail_nxt;
    logic [15:0]                                    rx_word_r, rx_word_nxt;
    logic [16:0]                                    dec;
    logic                                           manch_err;
    logic                                           bad;

    // frame: sync halves, then each bit as value and complement, odd parity last
    function automatic logic [39:0] build_frame(input logic cmd, input logic [15:0] w);
        logic [16:0] bits;
        logic [39:0] f;
        bits = {w, ~^w};
        f = {(cmd ? selftest_pkg::SYNC_COMMAND : selftest_pkg::SYNC_DATA), 34'h0};
        for (int k = 0; k < 17; k++) begin
            f[33-2*k] = bits[16-k];
            f[32-2*k] = ~bits[16-k];
        end
        return f;
    endfunction

    // decode the echo and grade it
    always_comb begin
        dec = 17'h00000;
        manch_err = 1'b0;
        for (int k = 0; k < 17; k++) begin
            dec[16-k] = rx_sh_r[33-2*k];
            manch_err = manch_err | (rx_sh_r[33-2*k] == rx_sh_r[32-2*k]);
        end
        bad = manch_err | ~(^dec) | (dec[16:1] != word_r)
            | (rx_sh_r[39:34] != (sync_r ? selftest_pkg::SYNC_COMMAND : selftest_pkg::SYNC_DATA));
    end

    // next state of the word engine
    always_comb begin
        state_nxt   = state_r;
        cyc_nxt     = cyc_r;
        idx_nxt     = idx_r;
        tx_sh_nxt   = tx_sh_r;
        rx_sh_nxt   = rx_sh_r;
        word_nxt    = word_r;
        sync_nxt    = sync_r;
        done_nxt    = 1'b0;
        fail_nxt    = fail_r;
        rx_word_nxt = rx_word_r;
        case (state_r)
            LB_IDLE: begin
                if (start) begin
                    tx_sh_nxt = build_frame(sync_cmd, word);
                    word_nxt  = word;
                    sync_nxt  = sync_cmd;
                    cyc_nxt   = '0;
                    idx_nxt   = 6'h00;
                    state_nxt = LB_SEND;
                end
            end
            LB_SEND: begin
                cyc_nxt = cyc_r + 1'b1;
                if (cyc_r == SAMPLE) begin
                    rx_sh_nxt = {rx_sh_r[38:0], rx_line};  // sample mid half-bit
                end
                if (cyc_r == ENDCYC) begin
                    cyc_nxt   = '0;
                    tx_sh_nxt = {tx_sh_r[38:0], 1'b0};
                    idx_nxt   = idx_r + 1'b1;
                    if (idx_r == selftest_pkg::LAST_HALF) begin
                        state_nxt   = LB_IDLE;
                        done_nxt    = 1'b1;
                        fail_nxt    = bad;
                        rx_word_nxt = dec[16:1];
                    end
                end
            end
            default: state_nxt = LB_IDLE;
        endcase
    end

    // word engine registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= LB_IDLE;
            cyc_r     <= '0;
            idx_r     <= 6'h00;
            tx_sh_r   <= 40'h0000000000;
            rx_sh_r   <= 40'h0000000000;
            word_r    <= 16'h0000;
            sync_r    <= 1'b0;
            done_r    <= 1'b0;
            fail_r    <= 1'b0;
            rx_word_r <= 16'h0000;
        end else begin
            state_r   <= state_nxt;
            cyc_r     <= cyc_nxt;
            idx_r     <= idx_nxt;
            tx_sh_r   <= tx_sh_nxt;
            rx_sh_r   <= rx_sh_nxt;
            word_r    <= word_nxt;
            sync_r    <= sync_nxt;
            done_r    <= done_nxt;
            fail_r    <= fail_nxt;
            rx_word_r <= rx_word_nxt;
        end
    end

    assign tx_line = tx_sh_r[39];
    assign tx_on   = (state_r == LB_SEND);
    assign done    = done_r;
    assign fail    = fail_r;
    assign rx_word = rx_word_r;

endmodule // loopback_word_engine

// File: design/ram_loopback_selftest.sv
// ram_loopback_selftest: self-test control register, ram test engine and loopback control
// assumes host register strobes and ram are on CLOCK; TEST_PIN and bus receivers are async
`timescale 1ns/1ps

module ram_loopback_selftest #(
    parameter int HALF_CYC = selftest_pkg::HALF_BIT_CYCLES
) (
    // clock and reset
    input  wire logic                         CLOCK,
    input  wire logic                         RST,
    // test mode pin
    input  wire logic                         TEST_PIN,
    // host register port
    input  wire logic [7:0]                   REG_ADDR,
    input  wire logic                         REG_WR,
    input  wire logic                         REG_RD,
    input  wire logic [15:0]                  REG_WDATA,
    output logic      [15:0]                  REG_RDATA,
    // normal-mode words shared at the multiplexed addresses
    input  wire logic [15:0]                  CMD_WORD,
    input  wire logic [15:0]                  MSG_INFO_WORD,
    input  wire logic [15:0]                  ALT_BIT_WORD,
    // ram test port, both halves at the same offset
    output logic [selftest_pkg::OFFSET_BITS-1:0] RAM_OFFSET,
    output logic                              RAM_WR,
    output logic                              RAM_RD,
    output logic [selftest_pkg::RAM_WIDTH-1:0] RAM_WDATA,
    input  wire logic [selftest_pkg::RAM_WIDTH-1:0] RAM_RDATA_LO,
    input  wire logic [selftest_pkg::RAM_WIDTH-1:0] RAM_RDATA_HI,
    // bus transceivers
    output selftest_pkg::bus_tx_type          BUS_A_TX,
    output selftest_pkg::bus_tx_type          BUS_B_TX,
    input  wire logic                         BUS_A_RX,
    input  wire logic                         BUS_B_RX
);
    typedef enum logic [1:0] {RB_IDLE, RB_WRITE, RB_READ, RB_CHECK} rb_state_type;

    selftest_pkg::control_type ctrl_r, ctrl_nxt;
    rb_state_type              rb_r, rb_nxt;
    logic [11:0]               off_r, off_nxt;
    logic [15:0]               fail_addr_r, fail_addr_nxt;
    logic [15:0]               lb_tx_r, lb_tx_nxt;
    logic [15:0]               lb_rx_r, lb_rx_nxt;
    logic [15:0]               rdata_r, rdata_nxt;
    selftest_pkg::bus_tx_type  bus_a_r, bus_a_nxt, bus_b_r, bus_b_nxt;
    logic                      test_meta_r, test_r;
    logic [1:0]                rx_meta_r, rx_r;
    logic                      ram_start, ram_done, ram_err, lb_start;
    logic                      lb_tx_line, lb_tx_on, lb_done, lb_fail, lb_rx_line;
    logic [15:0]               lb_rx_word;
    logic                      wr_ctrl;
    selftest_pkg::control_type wr_word;

    // pattern each ram location should hold, derived from its offset
    function automatic logic [15:0] pattern(input logic [11:0] o);
        return selftest_pkg::RAM_PATTERN ^ {o, o[3:0]};
    endfunction

    // two-stage synchronisers for the test pin and both bus receivers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            test_meta_r <= 1'b0;
            test_r      <= 1'b0;
            rx_meta_r   <= 2'h0;
            rx_r        <= 2'h0;
        end else begin
            test_meta_r <= TEST_PIN;
            test_r      <= test_meta_r;
            rx_meta_r   <= {BUS_B_RX, BUS_A_RX};
            rx_r        <= rx_meta_r;
        end
    end

    // control writes land only while the test pin is high
    assign wr_ctrl = REG_WR && (REG_ADDR == selftest_pkg::ADDR_CONTROL) && test_r;
    assign wr_word = selftest_pkg::control_type'(REG_WDATA);
    assign ram_start = wr_ctrl && wr_word.ram_test_go && !ctrl_r.ram_test_go
                     && ctrl_r.ram_access;
    assign lb_start  = wr_ctrl && wr_word.loopback_go && !ctrl_r.loopback_go;

    // ram test walk: write both halves, then read and compare both halves
    always_comb begin
        rb_nxt        = rb_r;
        off_nxt       = off_r;
        fail_addr_nxt = fail_addr_r;
        ram_done      = 1'b0;
        ram_err       = 1'b0;
        case (rb_r)
            RB_IDLE: begin
                if (ram_start) begin
                    off_nxt = 12'h000;
                    rb_nxt  = RB_WRITE;
                end
            end
            RB_WRITE: begin
                off_nxt = off_r + 1'b1;
                if (off_r == selftest_pkg::HALF_SPAN) begin
                    rb_nxt = RB_READ;
                end
            end
            RB_READ: rb_nxt = RB_CHECK;
            RB_CHECK: begin
                if (RAM_RDATA_LO != pattern(off_r) || RAM_RDATA_HI != pattern(off_r)) begin
                    ram_err       = 1'b1;
                    ram_done      = 1'b1;
                    fail_addr_nxt = {4'h0, off_r};
                    rb_nxt        = RB_IDLE;
                end else if (off_r == selftest_pkg::HALF_SPAN) begin
                    ram_done = 1'b1;
                    rb_nxt   = RB_IDLE;
                end else begin
                    off_nxt = off_r + 1'b1;
                    rb_nxt  = RB_READ;
                end
            end
            default: rb_nxt = RB_IDLE;
        endcase
    end

    // ram test registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rb_r        <= RB_IDLE;
            off_r       <= 12'h000;
            fail_addr_r <= selftest_pkg::WORD_RESET;
        end else begin
            rb_r        <= rb_nxt;
            off_r       <= off_nxt;
            fail_addr_r <= fail_addr_nxt;
        end
    end

    assign RAM_OFFSET = off_r;
    assign RAM_WR     = (rb_r == RB_WRITE);
    assign RAM_RD     = (rb_r == RB_READ);
    assign RAM_WDATA  = pattern(off_r);

    // loopback word engine and the echo path
    assign lb_rx_line = ctrl_r.loopback_analog_select
                      ? (ctrl_r.loopback_bus_select ? rx_r[1] : rx_r[0])
                      : lb_tx_line;

    loopback_word_engine #(.HALF_CYC(HALF_CYC)) lb_engine (
        .clk      (CLOCK),
        .rst      (RST),
        .start    (lb_start),
        .sync_cmd (wr_word.loopback_sync_select),
        .word     (lb_tx_r),
        .rx_line  (lb_rx_line),
        .tx_line  (lb_tx_line),
        .tx_on    (lb_tx_on),
        .done     (lb_done),
        .fail     (lb_fail),
        .rx_word  (lb_rx_word)
    );

    // control register, loopback data words, bus drive and read data
    always_comb begin
        ctrl_nxt  = ctrl_r;
        lb_tx_nxt = lb_tx_r;
        lb_rx_nxt = lb_rx_r;
        if (wr_ctrl) begin
            ctrl_nxt.ram_access             = wr_word.ram_access;
            ctrl_nxt.ram_protocol           = wr_word.ram_protocol;
            ctrl_nxt.loopback_analog_select = wr_word.loopback_analog_select;
            ctrl_nxt.loopback_sync_select   = wr_word.loopback_sync_select;
            ctrl_nxt.loopback_bus_select    = wr_word.loopback_bus_select;
        end
        if (REG_WR && REG_ADDR == selftest_pkg::ADDR_LB_TX && test_r) begin
            lb_tx_nxt = REG_WDATA;
        end
        // starts clear old results, completions set new ones and win
        if (ram_start) begin
            ctrl_nxt.ram_test_go        = 1'b1;
            ctrl_nxt.ram_test_fail_flag = 1'b0;
            ctrl_nxt.ram_test_pass_flag = 1'b0;
        end
        if (ram_done) begin
            ctrl_nxt.ram_test_go        = 1'b0;
            ctrl_nxt.ram_test_fail_flag = ram_err;
            ctrl_nxt.ram_test_pass_flag = !ram_err;
        end
        if (lb_start) begin
            ctrl_nxt.loopback_go        = 1'b1;
            ctrl_nxt.loopback_pass_flag = 1'b0;
            ctrl_nxt.loopback_fail_flag = 1'b0;
        end
        if (lb_done) begin
            ctrl_nxt.loopback_go        = 1'b0;
            ctrl_nxt.loopback_pass_flag = !lb_fail;
            ctrl_nxt.loopback_fail_flag = lb_fail;
            lb_rx_nxt                   = lb_rx_word;
        end
        ctrl_nxt.reserved14 = 1'b0;
        ctrl_nxt.unused     = 2'h0;
        bus_a_nxt.drive = lb_tx_on && ctrl_r.loopback_analog_select
                        && !ctrl_r.loopback_bus_select;
        bus_b_nxt.drive = lb_tx_on && ctrl_r.loopback_analog_select
                        && ctrl_r.loopback_bus_select;
        bus_a_nxt.level = bus_a_nxt.drive && lb_tx_line;
        bus_b_nxt.level = bus_b_nxt.drive && lb_tx_line;
        rdata_nxt = rdata_r;
        if (REG_RD) begin
            case (REG_ADDR)
                selftest_pkg::ADDR_CONTROL:   rdata_nxt = test_r ? ctrl_r : 16'h0000;
                selftest_pkg::ADDR_FAIL_ADDR: rdata_nxt = test_r ? fail_addr_r : MSG_INFO_WORD;
                selftest_pkg::ADDR_LB_TX:     rdata_nxt = test_r ? lb_tx_r : ALT_BIT_WORD;
                selftest_pkg::ADDR_CMD_WORD:  rdata_nxt = test_r ? lb_rx_r : CMD_WORD;
                default:                      rdata_nxt = 16'h0000;
            endcase
        end
    end

    // control and read-back registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl_r  <= selftest_pkg::CONTROL_RESET;
            lb_tx_r <= selftest_pkg::WORD_RESET;
            lb_rx_r <= selftest_pkg::WORD_RESET;
            rdata_r <= selftest_pkg::WORD_RESET;
            bus_a_r <= 2'h0;
            bus_b_r <= 2'h0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            lb_tx_r <= lb_tx_nxt;
            lb_rx_r <= lb_rx_nxt;
            rdata_r <= rdata_nxt;
            bus_a_r <= bus_a_nxt;
            bus_b_r <= bus_b_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign BUS_A_TX  = bus_a_r;
    assign BUS_B_TX  = bus_b_r;

    // checks next to the logic
    ram_fail_set_a: assert property (@(posedge CLOCK) disable iff (RST)
        (rb_r == RB_CHECK && ram_err) |=> ctrl_r.ram_test_fail_flag && !ctrl_r.ram_test_go)
        else $error("ram fail flag not set after a miscompare");
    ram_go_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ctrl_r.ram_test_go) |-> !ctrl_r.ram_test_fail_flag && !ctrl_r.ram_test_pass_flag)
        else $error("ram flags not cleared at start");
    fail_capture_a: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ctrl_r.ram_test_fail_flag) |-> fail_addr_r == {4'h0, $past(off_r)})
        else $error("fail offset not captured");
    info_word_mux_a: assert property (@(posedge CLOCK) disable iff (RST)
        (REG_RD && REG_ADDR == selftest_pkg::ADDR_FAIL_ADDR && !test_r)
        |=> REG_RDATA == $past(MSG_INFO_WORD))
        else $error("message word not returned with test low");
    unused_zero_a: assert property (@(posedge CLOCK) disable iff (RST)
        ctrl_r.unused == 2'h0
        && (!$past(REG_RD && REG_ADDR == selftest_pkg::ADDR_CONTROL) || REG_RDATA[7:6] == 2'h0))
        else $error("bits 7 and 6 not zero");
    digital_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
        !$past(ctrl_r.loopback_analog_select) |-> !BUS_A_TX.drive && !BUS_B_TX.drive)
        else $error("bus driven during digital loopback");
    bus_choice_a: assert property (@(posedge CLOCK) disable iff (RST)
        BUS_B_TX.drive |-> $past(ctrl_r.loopback_bus_select) && !BUS_A_TX.drive)
        else $error("wrong bus driven");
    lb_go_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ctrl_r.loopback_go) |-> $past(test_r))
        else $error("loopback started with test pin low");
    lb_result_a: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(ctrl_r.loopback_go) |-> ctrl_r.loopback_pass_flag ^ ctrl_r.loopback_fail_flag)
        else $error("loopback result not one-hot");
    ram_go_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ctrl_r.ram_test_go) |-> $past(test_r) && $past(ctrl_r.ram_access))
        else $error("ram test started without test pin and bit 15");

endmodule // ram_loopback_selftest

// File: design/selftest_pkg.sv
// selftest_pkg: register map, control word layout and timing for the self-test block
// assumes a 250 MHz system clock and a host register port on the same clock
package selftest_pkg;

    // register addresses seen by the host
    localparam logic [7:0] ADDR_CMD_WORD  = 8'h02;  // loopback receive word when test is high
    localparam logic [7:0] ADDR_FAIL_ADDR = 8'h1B;  // ram fail offset when test is high
    localparam logic [7:0] ADDR_LB_TX     = 8'h1F;  // loopback transmit word when test is high
    localparam logic [7:0] ADDR_CONTROL   = 8'h28;  // self-test control register

    // reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // self-test control register layout, bit 15 down to bit 0
    typedef struct packed {
        logic       ram_access;      // bit 15: unrestricted ram access
        logic       reserved14;      // bit 14: reads zero
        logic [2:0] ram_protocol;    // bits 13:11: ram test protocol select
        logic       ram_test_go;     // bit 10
        logic       ram_test_pass_flag;  // bit 9
        logic       ram_test_fail_flag;  // bit 8
        logic [1:0] unused;          // bits 7:6: always zero
        logic       loopback_analog_select;  // bit 5
        logic       loopback_sync_select;    // bit 4
        logic       loopback_bus_select;     // bit 3
        logic       loopback_go;     // bit 2
        logic       loopback_pass_flag;  // bit 1
        logic       loopback_fail_flag;  // bit 0
    } control_type;

    localparam control_type CONTROL_RESET = control_type'(16'h0000);

    // transmit side of one bus transceiver
    typedef struct packed {
        logic drive;  // output enable, high while the pin is driven
        logic level;  // line level
    } bus_tx_type;

    // ram geometry: two halves tested side by side
    localparam int          OFFSET_BITS   = 12;
    localparam int          RAM_WIDTH     = 16;
    localparam logic [11:0] HALF_SPAN     = 12'hFFF;     // last offset within a half
    localparam logic [15:0] HALF_DISTANCE = 16'h1000;    // second address of a fail
    localparam logic [15:0] RAM_PATTERN   = 16'hA5C3;    // base test pattern

    // loopback word timing and framing
    localparam int         CLOCK_MHZ       = 250;
    localparam int         HALF_BIT_NS     = 500;
    localparam int         HALF_BIT_CYCLES = (HALF_BIT_NS * CLOCK_MHZ) / 1000;
    localparam int         FRAME_HALVES    = 40;   // 6 sync halves and 17 manchester bits
    localparam logic [5:0] LAST_HALF       = 6'h27;
    localparam logic [5:0] SYNC_COMMAND    = 6'h38;  // high then low, three halves each
    localparam logic [5:0] SYNC_DATA       = 6'h07;  // low then high, three halves each

endpackage

// File: verification/far_side_model.sv
// far_side_model: both ram halves and the bus echo facing the self-test block
// assumes the block's clock; ram faults and echo faults are commanded by the bench
`timescale 1ns/1ps
module far_side_model #(
    parameter logic [11:0] FAULT_AT = 12'h3A5
) (
    // ram side
    input  wire logic        clk,
    input  wire logic [11:0] ram_offset,
    input  wire logic        ram_wr,
    input  wire logic        ram_rd,
    input  wire logic [15:0] ram_wdata,
    output logic      [15:0] rdata_lo,
    output logic      [15:0] rdata_hi,
    input  wire logic        fault_en,
    // bus side
    input  wire selftest_pkg::bus_tx_type bus_a,
    input  wire selftest_pkg::bus_tx_type bus_b,
    input  wire logic        echo_bad,
    output logic             rx_a,
    output logic             rx_b
);
    logic [15:0] lo [4096];
    logic [15:0] hi [4096];
    logic        idle_r = 1'b0;
    // upper half keeps a stuck bit when asked; stale read data is scrambled
    always @(posedge clk) begin
        idle_r <= ~idle_r;
        if (ram_wr) begin
            lo[ram_offset] <= ram_wdata;
            hi[ram_offset] <= ram_wdata ^ {15'h0000, fault_en && ram_offset == FAULT_AT};
        end
        if (ram_rd) {rdata_lo, rdata_hi} <= {lo[ram_offset], hi[ram_offset]};
        else {rdata_lo, rdata_hi} <= ~{rdata_lo, rdata_hi};
    end
    // a driven bus echoes, a released one toggles
    assign rx_a = bus_a.drive ? bus_a.level ^ echo_bad : idle_r;
    assign rx_b = bus_b.drive ? bus_b.level ^ echo_bad : idle_r;
endmodule // far_side_model

// File: verification/ram_loopback_selftest_tb.sv
// ram_loopback_selftest_tb: register-level checks of the self-test block
// assumes far_side_model supplies the ram and the bus echo
`timescale 1ns/1ps
module ram_loopback_selftest_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        test_pin = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, ram_wdata, lo, hi;
    logic [11:0] offset;
    logic        ram_wr, ram_rd, rx_a, rx_b;
    logic        fault_en = 1'b0;
    logic        echo_bad = 1'b0;
    logic [1:0]  seen = 2'b00;
    logic        clear_seen = 1'b0;
    selftest_pkg::bus_tx_type tx_a, tx_b;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    // loopback rows: expected bus drive {b,a} above the control word
    logic [17:0] rows [8] = '{18'h00004, 18'h0000C, 18'h00014, 18'h0001C,
                              18'h10024, 18'h2002C, 18'h10034, 18'h2003C};
    ram_loopback_selftest #(.HALF_CYC(8)) i_dut (.CLOCK(clock), .RST(rst), .TEST_PIN(test_pin),
        .REG_ADDR(addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .CMD_WORD(16'h0C0D), .MSG_INFO_WORD(16'h1B1B), .ALT_BIT_WORD(16'h1F1F),
        .RAM_OFFSET(offset), .RAM_WR(ram_wr), .RAM_RD(ram_rd), .RAM_WDATA(ram_wdata),
        .RAM_RDATA_LO(lo), .RAM_RDATA_HI(hi), .BUS_A_TX(tx_a), .BUS_B_TX(tx_b),
        .BUS_A_RX(rx_a), .BUS_B_RX(rx_b));
    far_side_model i_far (.clk(clock), .ram_offset(offset), .ram_wr(ram_wr), .ram_rd(ram_rd),
        .ram_wdata(ram_wdata), .rdata_lo(lo), .rdata_hi(hi), .fault_en(fault_en), .bus_a(tx_a),
        .bus_b(tx_b), .echo_bad(echo_bad), .rx_a(rx_a), .rx_b(rx_b));
    initial forever #2 clock = ~clock;
    // notes driven buses and cuts a hang short
    always @(posedge clock) begin
        seen <= clear_seen ? 2'b00 : seen | {tx_b.drive, tx_a.drive};
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        {addr, wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        {addr, reg_rd} <= {a, 1'b1};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        cmp($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic poll(input logic [15:0] m);
        rd(8'h28);
        for (int i = 0; i < 9000 && (rdata & m) !== 16'h0000; i++) rd(8'h28);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        check(8'h1B, 16'h1B1B);
        wr(8'h28, 16'h0004);
        test_pin <= 1'b1;
        repeat (2) @(posedge clock);
        check(8'h28, 16'h0000);
        wr(8'h28, 16'h00C0);
        check(8'h28, 16'h0000);
        // every bus, sync and loopback kind
        for (int i = 0; i < 8; i++) begin
            clear_seen <= 1'b1;
            wr(8'h1F, 16'hB700 + 16'(i));
            clear_seen <= 1'b0;
            wr(8'h28, rows[i][15:0]);
            poll(16'h0004);
            check(8'h28, rows[i][15:0] & 16'hFFFB | 16'h0002);
            check(8'h02, 16'hB700 + 16'(i));
            cmp("bus drive", {14'h0000, rows[i][17:16]}, {14'h0000, seen});
        end
        echo_bad = 1'b1;
        wr(8'h28, 16'h0024);
        poll(16'h0004);
        check(8'h28, 16'h0021);
        wr(8'h28, 16'h8400);
        check(8'h28, 16'h8001);
        wr(8'h28, 16'h8400);
        poll(16'h0400);
        check(8'h28, 16'h8201);
        fault_en = 1'b1;
        wr(8'h28, 16'h8400);
        poll(16'h0400);
        check(8'h28, 16'h8101);
        check(8'h1B, 16'h03A5);
        test_pin <= 1'b0;
        repeat (3) @(posedge clock);
        check(8'h1B, 16'h1B1B);
        rst <= 1'b1;
        test_pin <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check(8'h28, 16'h0000);
        close_out();
    end
endmodule // ram_loopback_selftest_tb
